// *** include/logic_clk_cfg_pkg.sv ***
// Purpose: shared constants for the logic-clock branch configuration block
// Assumes: 16-bit registers reached over a plain strobe port, 8-bit address
// Notes:   field positions and reset values live here and nowhere else
package logic_clk_cfg_pkg;

   localparam int          ADDR_W = 8;
   localparam int          DATA_W = 16;

   // register offsets
   localparam logic [7:0]  OFS_LOGIC_DIVIDER_FORMAT = 8'h08;
   localparam logic [7:0]  OFS_DIVIDER_CONTROL      = 8'h09;
   localparam logic [7:0]  OFS_COMMON_MODE          = 8'h20;
   localparam logic [7:0]  OFS_BLOCK_STATUS         = 8'h21;

   // values after reset
   localparam logic [15:0] RST_LOGIC_DIVIDER_FORMAT = 16'h0120;
   localparam logic [15:0] RST_DIVIDER_CONTROL      = 16'h0020;
   localparam logic [15:0] RST_COMMON_MODE          = 16'h0000;

   // writable bits; the rest read as zero
   localparam logic [15:0] WMASK_LOGIC_DIVIDER_FORMAT = 16'h01ff;
   localparam logic [15:0] WMASK_DIVIDER_CONTROL      = 16'hffff;
   localparam logic [15:0] WMASK_COMMON_MODE          = 16'h000f;

   // logic_divider_format fields
   localparam int          PRE_LSB       = 6;
   localparam int          LOGIC_EN_BIT  = 5;
   localparam int          SREF_FMT_LSB  = 2;
   localparam int          CLK_FMT_LSB   = 0;

   // divider_control fields
   localparam int          BIAS_LSB      = 14;
   localparam int          SYNC_BIT      = 13;
   localparam int          PD_BIT        = 12;
   localparam int          BYP_BIT       = 11;
   localparam int          POST_LSB      = 0;

   // common mode register fields
   localparam int          CLK_CM_LSB    = 0;
   localparam int          SREF_CM_LSB   = 2;

   // codes
   localparam logic [2:0]  PRE_DIV1      = 3'h1;
   localparam logic [2:0]  PRE_DIV2      = 3'h2;
   localparam logic [2:0]  PRE_DIV4      = 3'h4;
   localparam logic [1:0]  FMT_LVDS      = 2'h0;
   localparam logic [1:0]  FMT_CML       = 2'h2;
   localparam logic [9:0]  POST_MIN      = 10'h002;

   typedef enum logic [1:0] {
      BIAS_1V3, BIAS_1V1, BIAS_1V5, BIAS_OFF
   } sref_bias_t;

endpackage : logic_clk_cfg_pkg

// *** logic/clk_div_stage.sv ***
// Purpose: one counting stage of the logic-clock divide chain
// Assumes: step is a one-cycle enable at the stage input rate
// Notes:   tick is one cycle wide, once per ratio steps while run is high
`timescale 1ns/100ps
module clk_div_stage #(
   parameter int W = 10
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         run,
   input  wire logic         step,
   input  wire logic [W-1:0] ratio,
   output logic              tick
);

   logic [W-1:0] count_q;
   logic         last;

   if (W < 2) begin : g_bad_width
      $error("clk_div_stage needs W of at least 2");
   end

   // compare with >= so a ratio lowered mid-count cannot strand the counter
   assign last = count_q >= W'(ratio - W'(1));
   assign tick = run && step && last;

   always_ff @(posedge clk) begin
      if (!nrst || !run) begin
         count_q <= '0;
      end else if (step) begin
         count_q <= last ? '0 : count_q + W'(1);
      end
   end

endmodule : clk_div_stage

// *** logic/out_driver_cfg.sv ***
// Purpose: turns a format and common-mode code into driver controls
// Assumes: enable already folds in every power-down that applies
// Notes:   outputs are registered, one cycle behind the codes
`timescale 1ns/100ps
module out_driver_cfg
   import logic_clk_cfg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       enable,
   input  wire logic [1:0] format,
   input  wire logic [1:0] cm_code,
   output logic            lvds_on,
   output logic            cml_on,
   output logic [1:0]      cm_out,
   output logic            cm_valid
);

   logic lvds;

   assign lvds = enable && (format == FMT_LVDS);

   // reserved format codes leave both drivers off
   always_ff @(posedge clk) begin
      if (!nrst) begin
         lvds_on <= 1'b0;
         cml_on  <= 1'b0;
      end else begin
         lvds_on <= lvds;
         cml_on  <= enable && (format == FMT_CML);
      end
   end

   // common mode only matters to the lvds driver
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cm_out   <= 2'h0;
         cm_valid <= 1'b0;
      end else begin
         cm_out   <= lvds ? cm_code : 2'h0;
         cm_valid <= lvds;
      end
   end

endmodule : out_driver_cfg

// *** logic/logic_clock_divider_config.sv ***
// Purpose: configuration and divide chain of the logic-clock branch
// Assumes: clk stands in for the branch input clock
// Notes:   the divided logic clock leaves as a one-cycle enable pulse
//
// Overview of operation
// - prescale codes 1h, 2h, 4h divide by 1, 2, 4; others reserved; reset 4h
// - logic enable cleared shuts down logic clock and sref outputs entirely
// - sref output format bits 3-2: 0h lvds, 2h cml, others reserved
// - clock output format bits 1-0: 0h lvds, 2h cml, others reserved
// - sref request bias 0h 1.3V, 1h 1.1V, 2h 1.5V, 3h disabled
// - alignment bit enables sync path and capture; redundant when sref enabled
// - post-divider power-down stops post-divider, prescaler keeps running
// - bypass 0 engages post-divider, 1 takes output from prescaler directly
// - post-divider divides by code 2 to 1023; 0h and 1h reserved; reset 20h
// - lvds clock common mode follows its two-bit code, other formats ignore
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
module logic_clock_divider_config
   import logic_clk_cfg_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic              sref_enable,
   output logic                   logic_clock_tick,
   output logic                   prescaler_active,
   output logic                   postdiv_active,
   output logic                   clk_out_lvds_on,
   output logic                   clk_out_cml_on,
   output logic      [1:0]        clk_out_cm_code,
   output logic                   clk_out_cm_valid,
   output logic                   sref_out_lvds_on,
   output logic                   sref_out_cml_on,
   output logic      [1:0]        sref_out_cm_code,
   output logic                   sref_out_cm_valid,
   output logic                   sref_bias_enable,
   output logic      [1:0]        sref_bias_select,
   output logic                   sync_path_enable,
   output logic                   capture_permit
);

   logic [DATA_W-1:0] fmt_reg_q;
   logic [DATA_W-1:0] ctl_reg_q;
   logic [DATA_W-1:0] cm_reg_q;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] rdata_d;

   logic [2:0]        logic_prescale;
   logic              logic_en;
   logic [1:0]        logic_sref_out_format;
   logic [1:0]        logic_clock_out_format;
   sref_bias_t        sref_request_bias;
   logic              sync_en;
   logic              logic_postdiv_powerdown;
   logic              logic_postdiv_bypass;
   logic [9:0]        logic_postdiv_value;
   logic [1:0]        logic_clock_out_common_mode;
   logic [1:0]        logic_sref_out_common_mode;

   logic              pre_ok;
   logic              post_ok;
   logic [2:0]        pre_ratio;
   logic              pre_run;
   logic              post_run;
   logic              pre_tick;
   logic              post_tick;
   logic              out_tick;

   // field views
   assign logic_prescale          = fmt_reg_q[PRE_LSB +: 3];
   assign logic_en                = fmt_reg_q[LOGIC_EN_BIT];
   assign logic_sref_out_format   = fmt_reg_q[SREF_FMT_LSB +: 2];
   assign logic_clock_out_format  = fmt_reg_q[CLK_FMT_LSB +: 2];
   assign sref_request_bias       = sref_bias_t'(ctl_reg_q[BIAS_LSB +: 2]);
   assign sync_en                 = ctl_reg_q[SYNC_BIT];
   assign logic_postdiv_powerdown = ctl_reg_q[PD_BIT];
   assign logic_postdiv_bypass    = ctl_reg_q[BYP_BIT];
   assign logic_postdiv_value     = ctl_reg_q[POST_LSB +: 10];
   assign logic_clock_out_common_mode = cm_reg_q[CLK_CM_LSB +: 2];
   assign logic_sref_out_common_mode  = cm_reg_q[SREF_CM_LSB +: 2];

   // register writes; read-only bits are masked so they always read zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         fmt_reg_q <= RST_LOGIC_DIVIDER_FORMAT;
      end else if (reg_wr && reg_addr == OFS_LOGIC_DIVIDER_FORMAT) begin
         fmt_reg_q <= reg_wdata & WMASK_LOGIC_DIVIDER_FORMAT;
      end
   end

   // undisclosed bit 10 is stored as written; software keeps it 0
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctl_reg_q <= RST_DIVIDER_CONTROL;
      end else if (reg_wr && reg_addr == OFS_DIVIDER_CONTROL) begin
         ctl_reg_q <= reg_wdata & WMASK_DIVIDER_CONTROL;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cm_reg_q <= RST_COMMON_MODE;
      end else if (reg_wr && reg_addr == OFS_COMMON_MODE) begin
         cm_reg_q <= reg_wdata & WMASK_COMMON_MODE;
      end
   end

   assign status_word = {10'h000, sref_enable, sync_path_enable,
                         postdiv_active, prescaler_active,
                         !post_ok, !pre_ok};

   always_comb begin
      unique case (reg_addr)
         OFS_LOGIC_DIVIDER_FORMAT: rdata_d = fmt_reg_q;
         OFS_DIVIDER_CONTROL:      rdata_d = ctl_reg_q;
         OFS_COMMON_MODE:          rdata_d = cm_reg_q;
         OFS_BLOCK_STATUS:         rdata_d = status_word;
         default:                  rdata_d = '0;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rdata_d : '0;
      end
   end

   // prescale decode; a reserved code stops the chain rather than guess
   always_comb begin
      pre_ok    = 1'b1;
      pre_ratio = 3'h4;
      unique case (logic_prescale)
         PRE_DIV1: pre_ratio = 3'h1;
         PRE_DIV2: pre_ratio = 3'h2;
         PRE_DIV4: pre_ratio = 3'h4;
         default:  pre_ok    = 1'b0;
      endcase
   end

   assign post_ok  = logic_postdiv_value >= POST_MIN;
   assign pre_run  = logic_en && pre_ok;
   // power-down stops only the post stage; the prescaler keeps counting
   assign post_run = pre_run && post_ok
                     && !logic_postdiv_powerdown;

   // ratio 1 wraps on every step, so each step ticks: plain pass-through
   clk_div_stage #(
      .W     (3)
   ) u_prescale (
      .clk   (clk),
      .nrst  (nrst),
      .run   (pre_run),
      .step  (1'b1),
      .ratio (pre_ratio),
      .tick  (pre_tick)
   );

   clk_div_stage #(
      .W     (10)
   ) u_postdiv (
      .clk   (clk),
      .nrst  (nrst),
      .run   (post_run),
      .step  (pre_tick),
      .ratio (logic_postdiv_value),
      .tick  (post_tick)
   );

   // bypass takes the prescaler pulse straight to the output
   assign out_tick = logic_postdiv_bypass ? pre_tick
                                          : post_tick;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         logic_clock_tick <= 1'b0;
      end else begin
         logic_clock_tick <= logic_en && out_tick;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         prescaler_active <= 1'b0;
         postdiv_active   <= 1'b0;
      end else begin
         prescaler_active <= pre_run;
         postdiv_active   <= post_run;
      end
   end

   out_driver_cfg u_clk_driver (
      .clk      (clk),
      .nrst     (nrst),
      .enable   (logic_en),
      .format   (logic_clock_out_format),
      .cm_code  (logic_clock_out_common_mode),
      .lvds_on  (clk_out_lvds_on),
      .cml_on   (clk_out_cml_on),
      .cm_out   (clk_out_cm_code),
      .cm_valid (clk_out_cm_valid)
   );

   out_driver_cfg u_sref_driver (
      .clk      (clk),
      .nrst     (nrst),
      .enable   (logic_en),
      .format   (logic_sref_out_format),
      .cm_code  (logic_sref_out_common_mode),
      .lvds_on  (sref_out_lvds_on),
      .cml_on   (sref_out_cml_on),
      .cm_out   (sref_out_cm_code),
      .cm_valid (sref_out_cm_valid)
   );

   // bias code passes as is; code 3h turns the internal bias off
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sref_bias_enable <= 1'b1;
         sref_bias_select <= 2'h0;
      end else begin
         sref_bias_enable <= sref_request_bias != BIAS_OFF;
         sref_bias_select <= sref_request_bias;
      end
   end

   // sref enable already opens the sync path, so the bit adds nothing then
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sync_path_enable <= 1'b0;
         capture_permit   <= 1'b0;
      end else begin
         sync_path_enable <= sync_en || sref_enable;
         capture_permit   <= sync_en || sref_enable;
      end
   end

   // ---- assertions ----
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence s_read_at(logic [7:0] a);
      reg_rd && reg_addr == a;
   endsequence

   sequence s_pre4_quiet;
      (pre_tick && logic_prescale == PRE_DIV4 && !reg_wr)
         ##1 (!reg_wr) [*3];
   endsequence

   sequence s_pre2_quiet;
      (pre_tick && logic_prescale == PRE_DIV2 && !reg_wr) ##1 !reg_wr;
   endsequence

   a_reset_values: assert property ($rose(nrst) |->
      fmt_reg_q == RST_LOGIC_DIVIDER_FORMAT
      && ctl_reg_q == RST_DIVIDER_CONTROL)
      else $error("registers not at reset values after reset");

   a_read_format: assert property (
      s_read_at(OFS_LOGIC_DIVIDER_FORMAT) |=>
      reg_rdata == $past(fmt_reg_q))
      else $error("format register read back wrong");

   a_read_unmapped: assert property (
      (reg_rd && reg_addr != OFS_LOGIC_DIVIDER_FORMAT
       && reg_addr != OFS_DIVIDER_CONTROL
       && reg_addr != OFS_COMMON_MODE
       && reg_addr != OFS_BLOCK_STATUS) |=> reg_rdata == '0)
      else $error("unmapped read returned nonzero data");

   a_logic_off_silent: assert property (!logic_en |=>
      !logic_clock_tick && !clk_out_lvds_on && !clk_out_cml_on
      && !sref_out_lvds_on && !sref_out_cml_on)
      else $error("logic outputs alive while subsystem disabled");

   a_prescale_two: assert property (s_pre2_quiet |->
      !pre_tick ##1 pre_tick)
      else $error("prescale by two mistimed");

   a_prescale_four: assert property (s_pre4_quiet |=>
      pre_tick && !$past(pre_tick, 1) && !$past(pre_tick, 2))
      else $error("prescale by four mistimed");

   a_fmt_cml: assert property (
      (logic_en && logic_clock_out_format == FMT_CML) |=> clk_out_cml_on)
      else $error("clock output not cml for cml code");

   a_fmt_reserved: assert property (
      (logic_sref_out_format[0]) |=> !sref_out_lvds_on && !sref_out_cml_on)
      else $error("sref driver on for reserved format");

   a_bias_off: assert property (
      (sref_request_bias == BIAS_OFF) |=> !sref_bias_enable)
      else $error("sref bias left on for disabled code");

   a_sync_path: assert property (
      (sync_en || sref_enable) |=> sync_path_enable && capture_permit)
      else $error("sync path not enabled");

   a_pd_post_quiet: assert property (
      logic_postdiv_powerdown |-> !post_tick ##1 !postdiv_active)
      else $error("post divider runs while powered down");

   a_bypass_path: assert property (
      (logic_en && logic_postdiv_bypass) |=>
      logic_clock_tick == $past(pre_tick))
      else $error("bypass not taking prescaler pulse");

   a_post_reserved: assert property (
      (logic_postdiv_value < POST_MIN) |-> !post_tick)
      else $error("post divider ticks on reserved code");

   a_post_spacing: assert property (
      (post_tick && !reg_wr) |=> !post_tick)
      else $error("post divider ticked on consecutive cycles");

   a_cm_ignored: assert property (
      (logic_clock_out_format != FMT_LVDS) |=> !clk_out_cm_valid)
      else $error("common mode applied outside lvds format");

   a_cm_follows: assert property (
      (logic_en && logic_clock_out_format == FMT_LVDS) |=>
      clk_out_cm_valid
      && clk_out_cm_code == $past(logic_clock_out_common_mode))
      else $error("lvds common mode not following its code");

   a_sref_cm_ignored: assert property (
      (logic_sref_out_format != FMT_LVDS) |=> !sref_out_cm_valid)
      else $error("sref common mode applied outside lvds format");

   a_pd_keeps_pre: assert property (
      (logic_postdiv_powerdown && pre_run) |=> prescaler_active)
      else $error("prescaler stopped by post divider power-down");

endmodule : logic_clock_divider_config

// *** sim/logic_clock_divider_config_tb.sv ***
// Purpose: self-checking bench for the logic-clock branch configuration
// Assumes: clk also stands for the branch input clock
// Notes:   tick periods are counted in clk cycles between two pulses
`timescale 1ns/100ps
module logic_clock_divider_config_tb
   import logic_clk_cfg_pkg::*;
;
   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic              sref_enable = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic              logic_clock_tick, prescaler_active, postdiv_active;
   logic              clk_out_lvds_on, clk_out_cml_on, clk_out_cm_valid;
   logic              sref_out_lvds_on, sref_out_cml_on, sref_out_cm_valid;
   logic [1:0]        clk_out_cm_code, sref_out_cm_code, sref_bias_select;
   logic              sref_bias_enable, sync_path_enable, capture_permit;
   int                errors = 0;
   int                checks_done = 0;

   always #5 clk = ~clk;  // slow input keeps every stage in range

   logic_clock_divider_config dut_u (
      .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sref_enable(sref_enable), .logic_clock_tick(logic_clock_tick),
      .prescaler_active(prescaler_active), .postdiv_active(postdiv_active),
      .clk_out_lvds_on(clk_out_lvds_on), .clk_out_cml_on(clk_out_cml_on),
      .clk_out_cm_code(clk_out_cm_code), .clk_out_cm_valid(clk_out_cm_valid),
      .sref_out_lvds_on(sref_out_lvds_on), .sref_out_cml_on(sref_out_cml_on),
      .sref_out_cm_code(sref_out_cm_code),
      .sref_out_cm_valid(sref_out_cm_valid),
      .sref_bias_enable(sref_bias_enable),
      .sref_bias_select(sref_bias_select),
      .sync_path_enable(sync_path_enable), .capture_permit(capture_permit));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] exp,
                     input string what);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp, what);
   endtask : rd

   // drivers lag the register by one edge
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (logic_clock_tick !== 1'b1 && n < 3000);
   endtask : wait_tick

   // first two pulses are skipped, counters keep their count on a change
   task automatic per(input int exp, input string what);
      int n;
      wait_tick(n);
      wait_tick(n);
      wait_tick(n);
      chk(16'(n), 16'(exp), what);
   endtask : per

   task automatic no_tick(input string what);
      int n;
      n = 0;
      repeat (600) begin
         @(posedge clk);
         #1;
         if (logic_clock_tick !== 1'b0) n++;
      end
      chk(16'(n), 16'h0000, what);
   endtask : no_tick

   // extra bypass settings live outside this block; writes land nowhere
   task automatic path_regs;
      wr(8'h4f, 16'h0005);
      wr(8'h5a, 16'h0060);
   endtask : path_regs

   task automatic t_reset;
      rd(OFS_LOGIC_DIVIDER_FORMAT, 16'h0120, "fmt reg reset");
      rd(OFS_DIVIDER_CONTROL, 16'h0020, "ctl reg reset");
      rd(OFS_COMMON_MODE, 16'h0000, "cm reg reset");
      chk({15'h0, prescaler_active}, 16'h0001, "enabled at reset");
      per(128, "reset period");
   endtask : t_reset

   task automatic t_regs;
      wr(OFS_COMMON_MODE, 16'hffff);
      rd(OFS_COMMON_MODE, 16'h000f, "cm ro bits");
      wr(OFS_LOGIC_DIVIDER_FORMAT, 16'h01ef);
      rd(OFS_LOGIC_DIVIDER_FORMAT, 16'h01ef, "fmt rw bits");
      wr(OFS_DIVIDER_CONTROL, 16'hf3ff);
      rd(OFS_DIVIDER_CONTROL, 16'hf3ff, "ctl rw bits");
      wr(8'h30, 16'h1234);
      rd(8'h30, 16'h0000, "unmapped read");
      rd(OFS_LOGIC_DIVIDER_FORMAT, 16'h01ef, "fmt untouched");
      wr(OFS_LOGIC_DIVIDER_FORMAT, 16'h0120);
      wr(OFS_DIVIDER_CONTROL, 16'h0020);
   endtask : t_regs

   task automatic t_fmt;
      logic [1:0] c;
      logic       cl, sl;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         cl = (c == FMT_LVDS);
         sl = (~c == FMT_LVDS);
         wr(OFS_COMMON_MODE, {12'h0, c, ~c});
         wr(OFS_LOGIC_DIVIDER_FORMAT, {10'h004, 2'h2, ~c, c});
         settle();
         chk({11'h0, cl, c == FMT_CML, cl, cl ? ~c : 2'h0},
             {11'h0, clk_out_lvds_on, clk_out_cml_on, clk_out_cm_valid,
              clk_out_cm_code}, "clock driver");
         chk({11'h0, sl, ~c == FMT_CML, sl, sl ? c : 2'h0},
             {11'h0, sref_out_lvds_on, sref_out_cml_on, sref_out_cm_valid,
              sref_out_cm_code}, "sref driver");
      end
   endtask : t_fmt

   task automatic t_en;
      wr(OFS_LOGIC_DIVIDER_FORMAT, 16'h0100);
      settle();
      chk({8'h0, clk_out_lvds_on, clk_out_cml_on, clk_out_cm_valid,
           sref_out_lvds_on, sref_out_cml_on, sref_out_cm_valid,
           prescaler_active, postdiv_active}, 16'h0000, "all off");
      no_tick("disabled ticks");
   endtask : t_en

   task automatic t_bias;
      for (int b = 0; b < 4; b++) begin
         wr(OFS_DIVIDER_CONTROL, {2'(b), 14'h0020});
         settle();
         chk({13'h0, sref_bias_enable, sref_bias_select},
             {13'h0, b != 3, 2'(b)}, "bias");
      end
   endtask : t_bias

   task automatic t_sync;
      logic e;
      for (int k = 0; k < 4; k++) begin
         e = k[0] | k[1];
         @(posedge clk);
         sref_enable <= k[1];
         wr(OFS_DIVIDER_CONTROL, {2'h0, k[0], 13'h0020});
         settle();
         chk({14'h0, sync_path_enable, capture_permit}, {14'h0, e, e},
             "sync path");
      end
      @(posedge clk);
      sref_enable <= 1'b0;
   endtask : t_sync

   task automatic t_pre;
      wr(OFS_DIVIDER_CONTROL, 16'h0003);
      path_regs();
      for (int c = 0; c < 8; c++) begin
         wr(OFS_LOGIC_DIVIDER_FORMAT, {7'h0, 3'(c), 6'h20});
         if (c == 1 || c == 2 || c == 4) begin
            per(c * 3, "prescale period");
         end else begin
            no_tick("reserved prescale");
         end
      end
   endtask : t_pre

   task automatic t_post;
      wr(OFS_LOGIC_DIVIDER_FORMAT, 16'h0060);
      wr(OFS_DIVIDER_CONTROL, 16'h0002);
      per(2, "post min");
      wr(OFS_DIVIDER_CONTROL, 16'h03ff);
      per(1023, "post max");
      wr(OFS_DIVIDER_CONTROL, 16'h0001);
      no_tick("post code 1");
      chk({15'h0, postdiv_active}, 16'h0000, "post stopped");
      wr(OFS_DIVIDER_CONTROL, 16'h0000);
      no_tick("post code 0");
      rd(OFS_BLOCK_STATUS, 16'h0006, "status post reserved");
   endtask : t_post

   task automatic t_byp;
      wr(OFS_LOGIC_DIVIDER_FORMAT, 16'h0060);
      path_regs();
      wr(OFS_DIVIDER_CONTROL, 16'h0820);
      per(1, "bypass period");
      wr(OFS_DIVIDER_CONTROL, 16'h1820);
      per(1, "bypass with pd");
      chk({14'h0, prescaler_active, postdiv_active}, 16'h0002,
          "pd keeps prescaler");
      wr(OFS_DIVIDER_CONTROL, 16'h1020);
      no_tick("pd engaged");
      chk({15'h0, prescaler_active}, 16'h0001, "prescaler on");
   endtask : t_byp

   task automatic close_out;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   // about six to seven times the expected run length
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end

   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_regs();
      t_fmt();
      t_bias();
      t_sync();
      t_pre();
      t_post();
      t_byp();
      t_en();
      close_out();
   end
endmodule : logic_clock_divider_config_tb
